// >>> verilog/mcc_pkg.sv
// Constants, encodings and register map of the main clock controller
package mcc_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_HZ   = 50_000_000;
    localparam int CLK_PER_US    = CLK_FREQ_HZ / 1_000_000;
    localparam int T_STARTUP_NS  = 10_000;
    localparam int T_STAB_NS     = 40_000;
    localparam int STARTUP_CYC   = (T_STARTUP_NS * CLK_PER_US + 999) / 1000;
    localparam int STAB_CYC      = (T_STAB_NS * CLK_PER_US + 999) / 1000;
    localparam int CNT_W         = 12;
    localparam int LOCK_PERIODS  = 4;
    localparam int OPT_WAIT      = 3;

    // ==========================================================
    // Register map
    localparam int        AW             = 16;
    localparam logic [15:0] ADDR_CTRL     = 16'h0000;
    localparam logic [15:0] ADDR_TRIM     = 16'h0001;
    localparam logic [15:0] ADDR_STAT     = 16'h0002;
    localparam logic [15:0] ADDR_IRQ_STAT = 16'h0003;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h0004;
    localparam logic [15:0] ADDR_NV_TRIM5 = 16'hffde;
    localparam logic [15:0] ADDR_NV_TRIM3 = 16'hffdf;

    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] CTRL_MASK     = 8'h03;
    localparam logic [7:0] TRIM_RST      = 8'hff;
    localparam logic [7:0] NV_ERASED     = 8'hff;
    localparam int         CTRL_SLOW_BIT = 0;
    localparam int         CTRL_OUT_BIT  = 1;

    // Status register bits
    localparam int ST_LOCK   = 0;
    localparam int ST_STABLE = 1;
    localparam int ST_TLOCK  = 2;
    localparam int ST_SLOW   = 3;

    // Interrupt bits
    localparam int         IRQ_W       = 3;
    localparam int         IRQ_LOCK    = 0;
    localparam int         IRQ_TLOCK   = 1;
    localparam int         IRQ_UNLOCK  = 2;
    localparam logic [2:0] IRQ_RST     = 3'h0;

    // ==========================================================
    // Oscillator and multiplier models
    localparam int          ACC_W       = 16;
    localparam logic [15:0] RC_INC_MIN  = 16'h0300;
    localparam logic [15:0] RC_INC_STEP = 16'h0005;
    localparam int          MULT_W      = 6;
    localparam logic [5:0]  MULT_X4     = 6'h04;
    localparam logic [5:0]  MULT_X8     = 6'h08;
    localparam logic [5:0]  MULT_X32    = 6'h20;
    localparam int          SLOW_W      = 5;
    localparam logic [4:0]  SLOW_LAST   = 5'h1f;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MCC_SRC_RC, MCC_SRC_XTAL, MCC_SRC_EXT
    } mcc_src_type;

    typedef enum logic [1:0] {
        MCC_TREF_DIV2, MCC_TREF_EXT_X8, MCC_TREF_RC_X8
    } mcc_tref_type;

    typedef enum logic [1:0] {
        PLL_IDLE, PLL_START, PLL_LOCK, PLL_RUN
    } mcc_pll_state_type;

endpackage : mcc_pkg

// >>> verilog/mcc_clock_ctrl.sv
// Main clock source selection, PLLs, slow mode and RC trim registers
// Operation
// - Trim register resets to all ones
// - Trim zero fastest, all ones slowest
// - Main PLL multiplies reference by four or eight
// - PLL off, RC on: undivided RC clock
// - PLL and RC off: crystal or external clock direct
// - PLL holds output during start-up delay
// - Lock flag set, stable after further time
// - Control register resets zero, upper bits reserved
// - Control bit 1 enables clock output pin
// - Control bit 0 selects divide-by-32 slow mode
// - Timer PLL multiplies 8 MHz by four
// - Timer reference from halved, x8, or RC
// - Option bits select RC, crystal or external
// - Factory trim values held at fixed addresses
// - Factory trims erased when protection removed

// ==============================================================
// Frequency multiplier model
module mcc_pll
    import mcc_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               ce,
    // Control
    input  wire logic               run,
    input  wire logic               ref_tick,
    input  wire logic [MULT_W-1:0]  mult,
    // Result
    output logic                    out_tick,
    output logic                    pll_lock_flag,
    output logic                    stable
);
    import mcc_pkg::*;

    mcc_pll_state_type   state_ff;
    logic [ACC_W-1:0]    per_cnt_ff;
    logic [ACC_W-1:0]    per_last_ff;
    logic [ACC_W:0]      acc_ff;
    logic [ACC_W:0]      nxt_acc;
    logic [CNT_W-1:0]    wait_ff;
    logic [2:0]          match_ff;
    logic                near;

    assign near = (per_last_ff - per_cnt_ff) <= 16'h0002;

    // ==========================================================
    // Reference period measurement
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            per_cnt_ff  <= '0;
            per_last_ff <= '0;
        end else if (ce) begin
            if (ref_tick) begin
                per_cnt_ff  <= '0;
                per_last_ff <= per_cnt_ff + 16'h0001;
            end else if (per_cnt_ff != '1) begin
                per_cnt_ff <= per_cnt_ff + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Start-up, lock and stabilisation sequence
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= PLL_IDLE;
            wait_ff  <= '0;
            match_ff <= '0;
            stable   <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                state_ff <= PLL_IDLE;
                stable   <= 1'b0;
            end else begin
                unique case (state_ff)
                    PLL_IDLE: begin
                        state_ff <= PLL_START;
                        wait_ff  <= '0;
                    end
                    PLL_START: begin
                        wait_ff <= wait_ff + 12'h001;
                        if (wait_ff == CNT_W'(STARTUP_CYC - 1)) begin
                            state_ff <= PLL_LOCK;
                            match_ff <= '0;
                        end
                    end
                    PLL_LOCK: begin
                        if (ref_tick) begin
                            match_ff <= near ? match_ff + 3'h1 : 3'h0;
                            if (near && match_ff == 3'(LOCK_PERIODS - 1)) begin
                                state_ff <= PLL_RUN;
                                wait_ff  <= '0;
                            end
                        end
                    end
                    PLL_RUN: begin
                        if (wait_ff == CNT_W'(STAB_CYC - 1)) begin
                            stable <= 1'b1;
                        end else begin
                            wait_ff <= wait_ff + 12'h001;
                        end
                    end
                endcase
            end
        end
    end

    assign pll_lock_flag = (state_ff == PLL_RUN);

    // ==========================================================
    // Output edge generation, mult edges per reference period
    always_comb begin
        nxt_acc = acc_ff + {{(ACC_W + 1 - MULT_W){1'b0}}, mult};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_ff   <= '0;
            out_tick <= 1'b0;
        end else if (ce) begin
            out_tick <= 1'b0;
            if (state_ff == PLL_LOCK || state_ff == PLL_RUN) begin
                if (per_last_ff != '0 && nxt_acc >= {1'b0, per_last_ff}) begin
                    acc_ff   <= nxt_acc - {1'b0, per_last_ff};
                    out_tick <= 1'b1;
                end else begin
                    acc_ff <= nxt_acc;
                end
            end else begin
                acc_ff <= '0;
            end
        end
    end

endmodule // mcc_pll

// ==============================================================
// Clock controller top
module mcc_clock_ctrl
    import mcc_pkg::*;
#(
    parameter logic [7:0] TRIM_5V_INIT = 8'h80,
    parameter logic [7:0] TRIM_3V_INIT = 8'h80
)(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    // Register port
    input  wire logic [mcc_pkg::AW-1:0] addr,
    input  wire logic [7:0]           wr_data,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output logic [7:0]                rd_data,
    // Option bits
    input  wire logic [1:0]           opt_clk_src,
    input  wire logic                 opt_pll_en,
    input  wire logic                 opt_pll_x8,
    input  wire logic                 opt_timer_pll_en,
    input  wire logic [1:0]           opt_timer_ref,
    input  wire logic                 opt_readout_prot,
    // Power modes
    input  wire logic                 halt_req,
    input  wire logic                 auto_wake_halt,
    // Oscillator pins
    input  wire logic                 ext_clk_in,
    input  wire logic                 xtal_in,
    // Clock results
    output logic                      fosc_tick,
    output logic                      cpu_tick,
    output logic                      timer_tick,
    output logic                      clock_out,
    output logic                      clock_out_oe_n,
    output logic                      irq
);
    import mcc_pkg::*;

    localparam int SW = 10;

    logic [SW-1:0]         sync1_ff;
    logic [SW-1:0]         sync2_ff;
    logic [1:0]            pin_last_ff;
    logic [1:0]            opt_wait_ff;
    logic                  opt_valid_ff;
    mcc_src_type           src_ff;
    mcc_tref_type          tref_ff;
    logic                  pll_en_ff;
    logic                  pll_x8_ff;
    logic                  tpll_en_ff;
    logic                  prot_seen_ff;
    logic [7:0]            ctrl_ff;
    logic [7:0]            trim_ff;
    logic [7:0]            nv5_ff;
    logic [7:0]            nv3_ff;
    logic [IRQ_W-1:0]      irq_stat_ff;
    logic [IRQ_W-1:0]      irq_mask_ff;
    logic [ACC_W:0]        rc_acc_ff;
    logic                  rc_tick_ff;
    logic                  half_ff;
    logic [SLOW_W-1:0]     slow_cnt_ff;
    logic                  lock_last_ff;
    logic                  tlock_last_ff;
    logic                  ext_edge;
    logic                  xtal_edge;
    logic                  osc_edge;
    logic                  half_tick;
    logic                  src_tick;
    logic                  pll_ref;
    logic                  pll_tick;
    logic                  pll_pll_lock_flag;
    logic                  pll_stable;
    logic                  tpll_ref;
    logic                  tpll_pll_lock_flag;
    logic [MULT_W-1:0]     tmult;
    logic                  awake;
    logic                  nxt_fosc;
    logic [IRQ_W-1:0]      irq_set;
    logic [7:0]            status;

    // Trim zero gives the largest step, so the fastest clock
    function automatic logic [ACC_W-1:0] rc_step(input logic [7:0] trim);
        rc_step = RC_INC_MIN + RC_INC_STEP * {8'h00, ~trim};
    endfunction

    // ==========================================================
    // Pin and option synchronisers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            pin_last_ff <= '0;
        end else if (ce) begin
            sync1_ff    <= {opt_readout_prot, opt_timer_ref, opt_timer_pll_en,
                            opt_pll_x8, opt_pll_en, opt_clk_src,
                            xtal_in, ext_clk_in};
            sync2_ff    <= sync1_ff;
            pin_last_ff <= sync2_ff[1:0];
        end
    end

    assign ext_edge  = sync2_ff[0] && !pin_last_ff[0];
    assign xtal_edge = sync2_ff[1] && !pin_last_ff[1];

    // Option bits are caught once after reset release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            opt_wait_ff  <= '0;
            opt_valid_ff <= 1'b0;
            src_ff       <= MCC_SRC_RC;
            tref_ff      <= MCC_TREF_DIV2;
            pll_en_ff    <= 1'b0;
            pll_x8_ff    <= 1'b0;
            tpll_en_ff   <= 1'b0;
        end else if (ce && !opt_valid_ff) begin
            opt_wait_ff <= opt_wait_ff + 2'h1;
            if (opt_wait_ff == 2'(OPT_WAIT - 1)) begin
                opt_valid_ff <= 1'b1;
                src_ff       <= mcc_src_type'(sync2_ff[3:2]);
                pll_en_ff    <= sync2_ff[4];
                pll_x8_ff    <= sync2_ff[5];
                tpll_en_ff   <= sync2_ff[6];
                tref_ff      <= mcc_tref_type'(sync2_ff[8:7]);
            end
        end
    end

    // ==========================================================
    // RC oscillator model
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rc_acc_ff  <= '0;
            rc_tick_ff <= 1'b0;
        end else if (ce) begin
            rc_acc_ff  <= {1'b0, rc_acc_ff[ACC_W-1:0]}
                          + {1'b0, rc_step(trim_ff)};
            rc_tick_ff <= rc_acc_ff[ACC_W];
        end
    end

    // ==========================================================
    // Source selection and main PLL
    assign osc_edge = (src_ff == MCC_SRC_XTAL) ? xtal_edge : ext_edge;
    assign awake    = opt_valid_ff && !halt_req && !auto_wake_halt;

    always_comb begin
        unique case (src_ff)
            MCC_SRC_RC:   src_tick = rc_tick_ff;
            MCC_SRC_XTAL: src_tick = xtal_edge;
            MCC_SRC_EXT:  src_tick = ext_edge;
            default:      src_tick = 1'b0;
        endcase
    end

    assign pll_ref  = (src_ff == MCC_SRC_RC) ? rc_tick_ff : osc_edge;
    assign nxt_fosc = awake && (pll_en_ff ? pll_tick : src_tick);

    mcc_pll u_main_pll (
        .clock    (clock),
        .rst_n    (rst_n),
        .ce       (ce),
        .run      (awake && pll_en_ff),
        .ref_tick (pll_ref),
        .mult     (pll_x8_ff ? MULT_X8 : MULT_X4),
        .out_tick (pll_tick),
        .pll_lock_flag   (pll_pll_lock_flag),
        .stable   (pll_stable)
    );

    // ==========================================================
    // Timer PLL, fed with an 8 MHz equivalent reference
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            half_ff <= 1'b0;
        end else if (ce && osc_edge) begin
            half_ff <= !half_ff;
        end
    end

    assign half_tick = osc_edge && half_ff;

    always_comb begin
        unique case (tref_ff)
            MCC_TREF_DIV2: begin
                tpll_ref = half_tick;
                tmult    = MULT_X4;
            end
            MCC_TREF_EXT_X8: begin
                tpll_ref = half_tick;
                tmult    = MULT_X32;
            end
            MCC_TREF_RC_X8: begin
                tpll_ref = rc_tick_ff;
                tmult    = MULT_X32;
            end
            default: begin
                tpll_ref = 1'b0;
                tmult    = MULT_X4;
            end
        endcase
    end

    mcc_pll u_timer_pll (
        .clock    (clock),
        .rst_n    (rst_n),
        .ce       (ce),
        .run      (awake && tpll_en_ff),
        .ref_tick (tpll_ref),
        .mult     (tmult),
        .out_tick (timer_tick),
        .pll_lock_flag   (tpll_pll_lock_flag),
        .stable   ()
    );

    // ==========================================================
    // Oscillator clock, slow mode and clock output pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fosc_tick   <= 1'b0;
            cpu_tick    <= 1'b0;
            slow_cnt_ff <= '0;
        end else if (ce) begin
            fosc_tick <= nxt_fosc;
            cpu_tick  <= 1'b0;
            if (nxt_fosc) begin
                if (!ctrl_ff[CTRL_SLOW_BIT]) begin
                    cpu_tick    <= 1'b1;
                    slow_cnt_ff <= '0;
                end else begin
                    slow_cnt_ff <= slow_cnt_ff + 5'h01;
                    cpu_tick    <= (slow_cnt_ff == SLOW_LAST);
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clock_out      <= 1'b0;
            clock_out_oe_n <= 1'b1;
        end else if (ce) begin
            clock_out_oe_n <= !ctrl_ff[CTRL_OUT_BIT];
            if (!ctrl_ff[CTRL_OUT_BIT]) begin
                clock_out <= 1'b0;
            end else if (nxt_fosc) begin
                clock_out <= !clock_out;
            end
        end
    end

    // ==========================================================
    // Control and trim registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RST;
            trim_ff <= TRIM_RST;
        end else if (ce && wr_en) begin
            if (addr == ADDR_CTRL) begin
                ctrl_ff <= wr_data & CTRL_MASK;
            end
            if (addr == ADDR_TRIM) begin
                trim_ff <= wr_data;
            end
        end
    end

    // Factory trims, wiped when read-out protection is lifted
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            nv5_ff       <= TRIM_5V_INIT;
            nv3_ff       <= TRIM_3V_INIT;
            prot_seen_ff <= 1'b0;
        end else if (ce && opt_valid_ff) begin
            if (sync2_ff[9]) begin
                prot_seen_ff <= 1'b1;
            end else if (prot_seen_ff) begin
                prot_seen_ff <= 1'b0;
                nv5_ff       <= NV_ERASED;
                nv3_ff       <= NV_ERASED;
            end
        end
    end

    // ==========================================================
    // Interrupt status and mask
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lock_last_ff  <= 1'b0;
            tlock_last_ff <= 1'b0;
        end else if (ce) begin
            lock_last_ff  <= pll_pll_lock_flag;
            tlock_last_ff <= tpll_pll_lock_flag;
        end
    end

    always_comb begin
        irq_set             = '0;
        irq_set[IRQ_LOCK]   = pll_pll_lock_flag && !lock_last_ff;
        irq_set[IRQ_TLOCK]  = tpll_pll_lock_flag && !tlock_last_ff;
        irq_set[IRQ_UNLOCK] = !pll_pll_lock_flag && lock_last_ff;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_stat_ff <= IRQ_RST;
            irq_mask_ff <= IRQ_RST;
        end else if (ce) begin
            if (wr_en && addr == ADDR_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~wr_data[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
            if (wr_en && addr == ADDR_IRQ_MASK) begin
                irq_mask_ff <= wr_data[IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ==========================================================
    // Read port
    always_comb begin
        status            = '0;
        status[ST_LOCK]   = pll_pll_lock_flag;
        status[ST_STABLE] = pll_stable;
        status[ST_TLOCK]  = tpll_pll_lock_flag;
        status[ST_SLOW]   = ctrl_ff[CTRL_SLOW_BIT];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= '0;
            if (rd_en) begin
                unique case (addr)
                    ADDR_CTRL:     rd_data <= ctrl_ff;
                    ADDR_TRIM:     rd_data <= trim_ff;
                    ADDR_STAT:     rd_data <= status;
                    ADDR_IRQ_STAT: rd_data <= {5'h00, irq_stat_ff};
                    ADDR_IRQ_MASK: rd_data <= {5'h00, irq_mask_ff};
                    ADDR_NV_TRIM5: rd_data <= nv5_ff;
                    ADDR_NV_TRIM3: rd_data <= nv3_ff;
                    default:       rd_data <= '0;
                endcase
            end
        end
    end

endmodule // mcc_clock_ctrl

// >>> test/mcc_osc_model.sv
// Oscillator pin model for the clock controller
module mcc_osc_model #(
    parameter int EXT_HALF = 500,
    parameter int XT_HALF  = 120
)(
    // Oscillator pins
    output logic ext_clk_in,
    output logic xtal_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Free running sources
    initial begin
        ext_clk_in = 1'b0;
        forever #(EXT_HALF) ext_clk_in = ~ext_clk_in;
    end
    initial begin
        xtal_in = 1'b0;
        forever #(XT_HALF) xtal_in = ~xtal_in;
    end
endmodule // mcc_osc_model

// >>> test/mcc_checker.sv
// Port assertions for the clock controller
module mcc_checker
    import mcc_pkg::*;
(
    // Clock and inputs
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire logic       rd_en,
    input wire logic       opt_pll_en,
    input wire logic       opt_timer_pll_en,
    input wire logic       halt_req,
    input wire logic       auto_wake_halt,
    // Outputs
    input wire logic [7:0] rd_data,
    input wire logic       fosc_tick,
    input wire logic       cpu_tick,
    input wire logic       timer_tick,
    input wire logic       clock_out,
    input wire logic       clock_out_oe_n,
    input wire logic       irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [11:0] run_ff;
    // ====
    // Cycles since reset or halt
    always_ff @(posedge clock) begin
        if (!rst_n || halt_req || auto_wake_halt)
            run_ff <= 12'h000;
        else if (ce && run_ff != 12'hfff)
            run_ff <= run_ff + 12'h001;
    end
    sequence halted;
        halt_req [*4];
    endsequence
    rd_idle_a: assert property (
        $past(ce) && !$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data outside read cycle");
    rst_out_a: assert property (disable iff (1'b0)
        !rst_n |=> clock_out_oe_n && !irq && !clock_out)
        else $error("outputs not cleared by reset");
    oe_off_a: assert property (
        clock_out_oe_n && $past(clock_out_oe_n) |-> !clock_out)
        else $error("clock out while pin free");
    clk_out_a: assert property (
        !clock_out_oe_n && fosc_tick |-> clock_out != $past(clock_out))
        else $error("clock out not toggling");
    cpu_fast_a: assert property (
        cpu_tick |-> fosc_tick)
        else $error("cpu tick without osc tick");
    fosc_pulse_a: assert property (
        fosc_tick |=> !fosc_tick)
        else $error("osc tick longer than one cycle");
    startup_a: assert property (
        opt_pll_en && run_ff > 12'd3 && run_ff < STARTUP_CYC |-> !fosc_tick)
        else $error("pll clock during start-up");
    tmr_start_a: assert property (
        opt_timer_pll_en && run_ff > 12'd3 && run_ff < STARTUP_CYC
        |-> !timer_tick)
        else $error("timer clock during start-up");
    halt_stop_a: assert property (
        halted |-> !fosc_tick && !timer_tick)
        else $error("clock running in halt");
endmodule // mcc_checker

// >>> test/mcc_clock_ctrl_tb_top.sv
// Testbench top for the clock controller
module mcc_clock_ctrl_tb_top
    import mcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst_n, ce, wr_en, rd_en, halt_req, auto_wake_halt;
    logic        opt_pll_en, opt_pll_x8, opt_timer_pll_en, opt_readout_prot;
    logic        ext_clk_in, xtal_in, fosc_tick, cpu_tick, timer_tick;
    logic        clock_out, clock_out_oe_n, irq;
    logic [1:0]  opt_clk_src, opt_timer_ref;
    logic [15:0] addr;
    logic [7:0]  wr_data, rd_data;
    int          n_fail, cmp_count, nf, nc, nt, e;
    mcc_clock_ctrl mcc_clock_ctrl_inst (.*);
    mcc_osc_model mcc_osc_model_inst (.*);
    // ====
    // Tasks
    task automatic chk8(input string s, input logic [7:0] x, y);
        cmp_count++;
        if (y !== x) begin
            n_fail++;
            $display("Error %s exp %h got %h", s, x, y);
        end
    endtask
    task automatic chk_rng(input string s, input int lo, hi, v);
        cmp_count++;
        if (v < lo || v > hi) begin
            n_fail++;
            $display("Error %s exp %0d..%0d got %0d", s, lo, hi, v);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] x, string s);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        chk8(s, x, rd_data);
    endtask
    task automatic boot(input logic [1:0] s, input logic p, x, t);
        @(posedge clock);
        rst_n <= 1'b0;
        {opt_clk_src, opt_pll_en, opt_pll_x8, opt_timer_pll_en}
            <= {s, p, x, t};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
    endtask
    task automatic pause(input logic aw);
        @(posedge clock);
        {auto_wake_halt, halt_req} <= {aw, !aw};
        repeat (20) @(posedge clock);
        {auto_wake_halt, halt_req} <= 2'b00;
        repeat (1500) @(posedge clock);
    endtask
    task automatic count(input int w);
        {nf, nc, nt} = '0;
        repeat (w) begin
            @(negedge clock);
            nf += fosc_tick;
            nc += cpu_tick;
            nt += timer_tick;
        end
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #1_000_000;
        n_fail++;
        close_out;
    end
    // ====
    // Tests
    initial begin
        {rst_n, wr_en, rd_en, halt_req, auto_wake_halt, addr, wr_data} = '0;
        {opt_clk_src, opt_timer_ref, opt_pll_en, opt_pll_x8} = '0;
        {opt_timer_pll_en, opt_readout_prot, n_fail, cmp_count} = '0;
        ce = 1'b1;
        boot(2'h0, 1'b0, 1'b0, 1'b0);
        rd(ADDR_TRIM, TRIM_RST, "trim");
        rd(ADDR_CTRL, CTRL_RST, "ctrl");
        rd(ADDR_NV_TRIM5, 8'h80, "nv5");
        rd(ADDR_NV_TRIM3, 8'h80, "nv3");
        rd(16'h0010, 8'h00, "unmapped");
        wr(ADDR_CTRL, 8'hff);
        rd(ADDR_CTRL, CTRL_MASK, "ctrl bits");
        chk8("oe_n", 8'h00, {7'h00, clock_out_oe_n});
        wr(ADDR_CTRL, 8'h02);
        for (int t = 255; t >= 0; t -= 255) begin
            wr(ADDR_TRIM, 8'(t));
            count(2000);
            e = 2000 * (int'(RC_INC_MIN) + int'(RC_INC_STEP) * (255 - t));
            chk_rng("rc rate", e / 65536 - 2, e / 65536 + 2, nf);
        end
        wr(ADDR_CTRL, 8'h01);
        count(4096);
        e = 4096 * (int'(RC_INC_MIN) + int'(RC_INC_STEP) * 255) / 65536 / 32;
        chk_rng("slow", e - 1, e + 1, nc);
        $display("test regs and rc done");
        boot(2'h2, 1'b1, 1'b1, 1'b0);
        rd(ADDR_TRIM, TRIM_RST, "trim again");
        wr(ADDR_IRQ_MASK, 8'h01);
        repeat (3000) @(posedge clock);
        rd(ADDR_STAT, 8'h03, "lock");
        rd(ADDR_IRQ_STAT, 8'h01, "irq stat");
        chk8("irq on", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_STAT, 8'h01);
        @(negedge clock);
        chk8("irq off", 8'h00, {7'h00, irq});
        pause(1'b0);
        rd(ADDR_IRQ_STAT, 8'h05, "relock");
        count(2000);
        e = 2000 / CLK_PER_US * int'(MULT_X8);
        chk_rng("x8", e - e / 10, e + e / 10, nf);
        $display("test pll x8 done");
        boot(2'h2, 1'b1, 1'b0, 1'b0);
        wr(ADDR_TRIM, 8'h80);
        pause(1'b1);
        count(2000);
        e = 2000 / CLK_PER_US * int'(MULT_X4);
        chk_rng("x4", e - e / 10, e + e / 10, nf);
        $display("test pll x4 done");
        boot(2'h2, 1'b0, 1'b0, 1'b1);
        repeat (3000) @(posedge clock);
        rd(ADDR_STAT, 8'h04, "timer lock");
        count(2000);
        e = 2000 / CLK_PER_US;
        chk_rng("ext", e - 1, e + 1, nf);
        e = e / 2 * 4;
        chk_rng("timer", e - e / 10, e + e / 10, nt);
        @(posedge clock);
        opt_readout_prot <= 1'b1;
        repeat (10) @(posedge clock);
        opt_readout_prot <= 1'b0;
        repeat (10) @(posedge clock);
        rd(ADDR_NV_TRIM5, NV_ERASED, "erase5");
        rd(ADDR_NV_TRIM3, NV_ERASED, "erase3");
        $display("test ext and timer done");
        close_out;
    end
endmodule // mcc_clock_ctrl_tb_top
bind mcc_clock_ctrl mcc_checker mcc_checker_inst (.*);
